// ### design/tsrm_pkg.sv
// Register map constants for the temperature sensor register bank.
// Assumes an 8-bit register pointer supplied by the serial protocol engine.
package tsrm_pkg;
   localparam logic [7:0] ADDR_LOCAL_TEMP = 8'h00;
   localparam logic [7:0] ADDR_REMOTE_HI = 8'h01;
   localparam logic [7:0] ADDR_ALERT_FLAGS = 8'h02;
   localparam logic [7:0] ADDR_CONFIG = 8'h03;
   localparam logic [7:0] ADDR_CONFIG_ALIAS = 8'h09;
   localparam logic [7:0] ADDR_CONV_INT = 8'h04;
   localparam logic [7:0] ADDR_CONV_INT_ALIAS = 8'h0A;
   localparam logic [7:0] ADDR_LOCAL_HIGH = 8'h05;
   localparam logic [7:0] ADDR_LOCAL_HIGH_ALIAS = 8'h0B;
   localparam logic [7:0] ADDR_RSVD_A = 8'h06;
   localparam logic [7:0] ADDR_RHL_HI = 8'h07;
   localparam logic [7:0] ADDR_RHL_HI_ALIAS = 8'h0D;
   localparam logic [7:0] ADDR_RLL_HI = 8'h08;
   localparam logic [7:0] ADDR_RLL_HI_ALIAS = 8'h0E;
   localparam logic [7:0] ADDR_RSVD_B = 8'h0C;
   localparam logic [7:0] ADDR_ONE_SHOT = 8'h0F;
   localparam logic [7:0] ADDR_REMOTE_LO = 8'h10;
   localparam logic [7:0] ADDR_ADJ_HI = 8'h11;
   localparam logic [7:0] ADDR_ADJ_LO = 8'h12;
   localparam logic [7:0] ADDR_RHL_LO = 8'h13;
   localparam logic [7:0] ADDR_RLL_LO = 8'h14;
   localparam logic [7:0] ADDR_ALERT_MASK = 8'h16;
   localparam logic [7:0] ADDR_REMOTE_CRIT = 8'h19;
   localparam logic [7:0] ADDR_LOCAL_CRIT = 8'h20;
   localparam logic [7:0] ADDR_CRIT_HYST = 8'h21;
   localparam logic [7:0] ADDR_RECORD_1 = 8'h2D;
   localparam logic [7:0] ADDR_RECORD_2 = 8'h2E;
   localparam logic [7:0] ADDR_RECORD_3 = 8'h2F;
   localparam logic [7:0] ADDR_FILTER_ALERT = 8'hBF;
   localparam logic [7:0] ADDR_CHIP_IDENTITY = 8'hFD;
   localparam logic [7:0] ADDR_MAKER_ID = 8'hFE;
   localparam logic [7:0] ADDR_DEVREV_ID = 8'hFF;

   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_CONFIG = 8'h05;
   localparam logic [7:0] RST_CONV_INT = 8'h08;
   localparam logic [7:0] RST_HIGH_LIMIT = 8'h46;
   localparam logic [7:0] RST_LOW_LIMIT = 8'hD8;
   localparam logic [7:0] RST_ALERT_MASK = 8'h07;
   localparam logic [7:0] RST_CRIT_HYST = 8'h0A;

   // Alert flag bit positions; bits 7 and 2 are live status and bit 5 reads zero, none are latched flags
   localparam int FLG_BUSY = 7;
   localparam int FLG_LOCAL_HIGH = 6;
   localparam int FLG_REMOTE_HIGH = 4;
   localparam int FLG_REMOTE_LOW = 3;
   localparam int FLG_REMOTE_OPEN = 2;
   localparam int FLG_REMOTE_CRIT = 1;
   localparam int FLG_LOCAL_CRIT = 0;
   localparam logic [7:0] FLG_LATCH_MASK = 8'h5B;
   localparam int CFG_ALERT_MASK_BIT = 7;
   localparam int FLT_ALERT_MODE_BIT = 0;

   localparam int REMOTE_W = 11;
   localparam int REMOTE_PAD = 5;
endpackage : tsrm_pkg

// ### design/tsrm_reg_bank.sv
// Register bank of a local and remote temperature sensor.
// Assumes a protocol engine that presents a pointer with one-cycle read and
// write strobes, and a conversion engine that pulses a done strobe.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: Local result at 00h, 8-bit two's complement, 1 degree per count, read-only, resets zero.
// R2: Remote result held as 11-bit two's complement, one eighth degree per count.
// R3: Pointer 01h returns remote result bits ten to three, read-only, resets zero.
// R4: Pointer 10h returns remaining low remote bits, read-only, resets zero.
// R5: High then low byte read as word is left-justified, five low bits zero.
// R6: Configuration, period and three limits answer at two pointers, one storage.
// R7: Limits reset to 46h, 46h and D8h; remote limit low bytes reset zero.
// R8: Write-only one-shot at 0Fh, reads zero; a write requests one conversion.
// R9: Remote adjustment high at 11h and low at 12h, read-write, reset zero.
// R10: Remote critical limit at 19h read-write, reset value taken at power-up.
// R11: Local critical 20h loaded at power-up; hysteresis at 21h resets 0Ah.
// R12: Filter and alert-mode register at BFh, read-write, resets zero.
// R13: Read-only identity codes at FDh, FEh and FFh.
// R14: Reading alert flags clears limit flags; later conversion may set again.
// R15: Writes to read-only or unmapped pointers are dropped and answered not-acknowledge.
// R16: Reserved and unlisted pointers read zero and change nothing.
// R17: Alert mask at 16h resets 07h; data records 2Dh to 2Fh reset zero.
module tsrm_reg_bank
   import tsrm_pkg::*;
#(
   parameter logic [7:0] CHIP_IDENTITY = 8'hA1,   // Arbitrary value
   parameter logic [7:0] MAKER_ID = 8'hB2,  // Arbitrary value
   parameter logic [7:0] DEVREV_ID = 8'hC3  // Arbitrary value
)(
   input wire logic CLOCK_I,               // 25 MHz clock
   input wire logic SRST_I,                // Synchronous reset, active high
   input wire logic [7:0] PTR_I,           // Register pointer
   input wire logic WR_I,                  // Write strobe, one cycle
   input wire logic [7:0] WDATA_I,         // Write data
   input wire logic RD_I,                  // Read strobe, one cycle
   output logic [7:0] RDATA_O,             // Read data, registered
   output logic WR_NACK_O,                 // Write refused, registered pulse
   input wire logic [7:0] REMOTE_CRIT_INIT_I, // Power-up remote critical limit
   input wire logic [7:0] LOCAL_CRIT_INIT_I,  // Power-up local critical limit
   input wire logic CONV_DONE_I,           // Conversion done pulse
   input wire logic CONV_BUSY_I,           // Conversion in progress
   input wire logic REMOTE_OPEN_I,         // Remote diode open
   input wire logic [7:0] LOCAL_TEMP_I,    // Local conversion
   input wire logic [10:0] REMOTE_RAW_I,   // Remote conversion before adjust
   input wire logic [7:0] LIMIT_EVENTS_I,  // Limit events of the conversion
   input wire logic ARA_HIT_I,             // Alert response address answered
   output logic ONE_SHOT_O,                // One-shot request pulse, registered
   output logic [7:0] CONFIG_O,            // Configuration value
   output logic [7:0] CONV_INT_O,          // Conversion interval
   output logic [7:0] LOCAL_HIGH_O,        // Local high limit
   output logic [15:0] REMOTE_HIGH_O,      // Remote high limit word
   output logic [15:0] REMOTE_LOW_O,       // Remote low limit word
   output logic [7:0] ALERT_SRC_MASK_O,    // Alert source mask
   output logic [7:0] REMOTE_CRIT_O,       // Remote critical limit
   output logic [7:0] LOCAL_CRIT_O,        // Local critical limit
   output logic [7:0] CRIT_HYST_O,         // Critical hysteresis
   output logic [7:0] FILTER_ALERT_O,      // Filter and alert mode
   output logic [10:0] REMOTE_TEMP_O       // Adjusted remote result
);
   tsrm_result_if res ();

   logic [7:0] cfg_q, conv_q, lhigh_q, rhh_q, rlh_q, rhl_q, rll_q;
   logic [7:0] adj_hi_q, adj_lo_q, amask_q, rcrit_q, lcrit_q, hyst_q;
   logic [7:0] rec1_q, rec2_q, rec3_q, filt_q, flags_q;
   logic [7:0] rdata_q, rdata_d;
   logic nack_q, one_shot_q, crit_loaded_q;
   logic writable;
   logic [10:0] adj_w;
   logic [10:0] remote_adj;
   logic [15:0] remote_word;
   logic flags_read;
   logic [7:0] flags_now;

   // Offset bits line up with the result: high byte then top three of low byte
   assign adj_w = {adj_hi_q, adj_lo_q[7:REMOTE_PAD]};
   assign remote_adj = REMOTE_RAW_I + adj_w; // R9

   tsrm_result_latch u_latch (
      .clk_i(CLOCK_I),
      .rst_i(SRST_I),
      .done_i(CONV_DONE_I),
      .busy_i(CONV_BUSY_I),
      .open_i(REMOTE_OPEN_I),
      .local_i(LOCAL_TEMP_I),
      .remote_i(remote_adj),
      .flags_i(LIMIT_EVENTS_I),
      .res(res)
   );

   assign remote_word = {res.remote_temp, {REMOTE_PAD{1'b0}}}; // R5

   always_comb begin
      unique case (PTR_I)
         ADDR_CONFIG, ADDR_CONFIG_ALIAS, ADDR_CONV_INT, ADDR_CONV_INT_ALIAS,
         ADDR_LOCAL_HIGH, ADDR_LOCAL_HIGH_ALIAS, ADDR_RHL_HI, ADDR_RHL_HI_ALIAS,
         ADDR_RLL_HI, ADDR_RLL_HI_ALIAS, ADDR_ONE_SHOT, ADDR_ADJ_HI, ADDR_ADJ_LO,
         ADDR_RHL_LO, ADDR_RLL_LO, ADDR_ALERT_MASK, ADDR_REMOTE_CRIT,
         ADDR_LOCAL_CRIT, ADDR_CRIT_HYST, ADDR_RECORD_1, ADDR_RECORD_2,
         ADDR_RECORD_3, ADDR_FILTER_ALERT: writable = 1'b1;
         default: writable = 1'b0; // R15
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         nack_q <= 1'b0;
         one_shot_q <= 1'b0;
      end else begin
         nack_q <= WR_I && !writable; // R15
         one_shot_q <= WR_I && (PTR_I == ADDR_ONE_SHOT); // R8
      end
   end

   // Configuration: alert mask bit also set by an alerting status read while filter bit 0 is clear, or by an ARA
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         cfg_q <= RST_CONFIG;
      end else if (WR_I && (PTR_I == ADDR_CONFIG || PTR_I == ADDR_CONFIG_ALIAS)) begin
         cfg_q <= WDATA_I; // R6
      end else if ((flags_read && (|(flags_q & FLG_LATCH_MASK))
                    && !filt_q[FLT_ALERT_MODE_BIT]) || ARA_HIT_I) begin
         cfg_q[CFG_ALERT_MASK_BIT] <= 1'b1;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         conv_q <= RST_CONV_INT;
         lhigh_q <= RST_HIGH_LIMIT; // R7
         rhh_q <= RST_HIGH_LIMIT; // R7
         rlh_q <= RST_LOW_LIMIT; // R7
         rhl_q <= RST_ZERO; // R7
         rll_q <= RST_ZERO; // R7
         adj_hi_q <= RST_ZERO; // R9
         adj_lo_q <= RST_ZERO; // R9
         amask_q <= RST_ALERT_MASK; // R17
         hyst_q <= RST_CRIT_HYST; // R11
         rec1_q <= RST_ZERO; // R17
         rec2_q <= RST_ZERO; // R17
         rec3_q <= RST_ZERO; // R17
         filt_q <= RST_ZERO; // R12
      end else if (WR_I) begin
         unique case (PTR_I)
            ADDR_CONV_INT, ADDR_CONV_INT_ALIAS: conv_q <= WDATA_I; // R6
            ADDR_LOCAL_HIGH, ADDR_LOCAL_HIGH_ALIAS: lhigh_q <= WDATA_I; // R6
            ADDR_RHL_HI, ADDR_RHL_HI_ALIAS: rhh_q <= WDATA_I; // R6
            ADDR_RLL_HI, ADDR_RLL_HI_ALIAS: rlh_q <= WDATA_I; // R6
            ADDR_RHL_LO: rhl_q <= WDATA_I;
            ADDR_RLL_LO: rll_q <= WDATA_I;
            ADDR_ADJ_HI: adj_hi_q <= WDATA_I; // R9
            ADDR_ADJ_LO: adj_lo_q <= WDATA_I; // R9
            ADDR_ALERT_MASK: amask_q <= WDATA_I; // R17
            ADDR_CRIT_HYST: hyst_q <= WDATA_I; // R11
            ADDR_RECORD_1: rec1_q <= WDATA_I; // R17
            ADDR_RECORD_2: rec2_q <= WDATA_I; // R17
            ADDR_RECORD_3: rec3_q <= WDATA_I; // R17
            ADDR_FILTER_ALERT: filt_q <= WDATA_I; // R12
            default: ; // R16
         endcase
      end
   end

   // Critical limits take their strap value on the first cycle after reset release
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         crit_loaded_q <= 1'b0;
         rcrit_q <= RST_ZERO;
         lcrit_q <= RST_ZERO;
      end else if (!crit_loaded_q) begin
         crit_loaded_q <= 1'b1;
         rcrit_q <= REMOTE_CRIT_INIT_I; // R10
         lcrit_q <= LOCAL_CRIT_INIT_I; // R11
      end else if (WR_I && PTR_I == ADDR_REMOTE_CRIT) begin
         rcrit_q <= WDATA_I; // R10
      end else if (WR_I && PTR_I == ADDR_LOCAL_CRIT) begin
         lcrit_q <= WDATA_I; // R11
      end
   end

   assign flags_read = RD_I && (PTR_I == ADDR_ALERT_FLAGS);

   // A new event in the clearing cycle survives the read
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         flags_q <= RST_ZERO;
      end else begin
         flags_q <= (flags_read ? 8'h00 : flags_q) | res.flags_set; // R14
      end
   end

   always_comb begin
      flags_now = flags_q & FLG_LATCH_MASK;
      flags_now[FLG_BUSY] = res.busy;
      flags_now[FLG_REMOTE_OPEN] = res.remote_open;
   end

   always_comb begin
      unique case (PTR_I)
         ADDR_LOCAL_TEMP: rdata_d = res.local_temp; // R1
         ADDR_REMOTE_HI: rdata_d = remote_word[15:8]; // R3
         ADDR_REMOTE_LO: rdata_d = remote_word[7:0]; // R4
         ADDR_ALERT_FLAGS: rdata_d = flags_now;
         ADDR_CONFIG, ADDR_CONFIG_ALIAS: rdata_d = cfg_q; // R6
         ADDR_CONV_INT, ADDR_CONV_INT_ALIAS: rdata_d = conv_q; // R6
         ADDR_LOCAL_HIGH, ADDR_LOCAL_HIGH_ALIAS: rdata_d = lhigh_q; // R6
         ADDR_RHL_HI, ADDR_RHL_HI_ALIAS: rdata_d = rhh_q; // R6
         ADDR_RLL_HI, ADDR_RLL_HI_ALIAS: rdata_d = rlh_q; // R6
         ADDR_RHL_LO: rdata_d = rhl_q;
         ADDR_RLL_LO: rdata_d = rll_q;
         ADDR_ADJ_HI: rdata_d = adj_hi_q;
         ADDR_ADJ_LO: rdata_d = adj_lo_q;
         ADDR_ALERT_MASK: rdata_d = amask_q;
         ADDR_REMOTE_CRIT: rdata_d = rcrit_q;
         ADDR_LOCAL_CRIT: rdata_d = lcrit_q;
         ADDR_CRIT_HYST: rdata_d = hyst_q;
         ADDR_RECORD_1: rdata_d = rec1_q;
         ADDR_RECORD_2: rdata_d = rec2_q;
         ADDR_RECORD_3: rdata_d = rec3_q;
         ADDR_FILTER_ALERT: rdata_d = filt_q;
         ADDR_CHIP_IDENTITY: rdata_d = CHIP_IDENTITY; // R13
         ADDR_MAKER_ID: rdata_d = MAKER_ID; // R13
         ADDR_DEVREV_ID: rdata_d = DEVREV_ID; // R13
         default: rdata_d = 8'h00; // R16
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         rdata_q <= 8'h00;
      end else if (RD_I) begin
         rdata_q <= rdata_d;
      end
   end

   assign RDATA_O = rdata_q;
   assign WR_NACK_O = nack_q;
   assign ONE_SHOT_O = one_shot_q;
   assign CONFIG_O = cfg_q;
   assign CONV_INT_O = conv_q;
   assign LOCAL_HIGH_O = lhigh_q;
   assign REMOTE_HIGH_O = {rhh_q, rhl_q};
   assign REMOTE_LOW_O = {rlh_q, rll_q};
   assign ALERT_SRC_MASK_O = amask_q;
   assign REMOTE_CRIT_O = rcrit_q;
   assign LOCAL_CRIT_O = lcrit_q;
   assign CRIT_HYST_O = hyst_q;
   assign FILTER_ALERT_O = filt_q;
   assign REMOTE_TEMP_O = res.remote_temp;
endmodule : tsrm_reg_bank
`default_nettype wire

// ### design/tsrm_result_if.sv
// Carries conversion results from the result latch to the register bank.
// Assumes a single clock domain.
`timescale 1ns/1ps
`default_nettype none
interface tsrm_result_if;
   logic [7:0] local_temp;
   logic [10:0] remote_temp;
   logic [7:0] flags_set;
   logic busy;
   logic remote_open;
   modport src (output local_temp, remote_temp, flags_set, busy, remote_open);
   modport dst (input local_temp, remote_temp, flags_set, busy, remote_open);
endinterface : tsrm_result_if
`default_nettype wire

// ### design/tsrm_result_latch.sv
// Latches conversion results at the end of each conversion; limit events pass through unregistered in the done cycle.
// Assumes the conversion engine pulses done with results valid in that cycle.
`timescale 1ns/1ps
`default_nettype none
module tsrm_result_latch
   import tsrm_pkg::*;
(
   input wire logic clk_i,                 // Clock
   input wire logic rst_i,                 // Synchronous reset
   input wire logic done_i,                // Conversion done pulse
   input wire logic busy_i,                // Conversion in progress
   input wire logic open_i,                // Remote diode open
   input wire logic [7:0] local_i,         // Local result
   input wire logic [10:0] remote_i,       // Remote result, offset applied
   input wire logic [7:0] flags_i,         // Limit events of this conversion
   tsrm_result_if.src res                  // Toward the bank
);
   logic [7:0] local_q;
   logic [10:0] remote_q;
   logic busy_q;
   logic open_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         local_q <= RST_ZERO;    // R1
         remote_q <= '0;         // R2
      end else if (done_i) begin
         local_q <= local_i;     // R1
         remote_q <= remote_i;   // R2
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_q <= 1'b0;
         open_q <= 1'b0;
      end else begin
         busy_q <= busy_i;
         open_q <= open_i;
      end
   end

   assign res.local_temp = local_q;
   assign res.remote_temp = remote_q;
   assign res.flags_set = done_i ? (flags_i & FLG_LATCH_MASK) : 8'h00;
   assign res.busy = busy_q;
   assign res.remote_open = open_q;
endmodule : tsrm_result_latch
`default_nettype wire

// ### tb/tsrm_host_model.sv
// Host side of the register pointer interface: single reads and writes.
// Assumes strobes are sampled on the rising edge; drives on the falling one.
`timescale 1ns/1ps
`default_nettype none
module tsrm_host_model (
   input wire logic clk_i, // Clock
   input wire logic [7:0] rdata_i, // Read data
   input wire logic nack_i, // Refusal
   output logic [7:0] ptr_o, // Pointer
   output logic wr_o, // Write
   output logic [7:0] wdata_o, // Data
   output logic rd_o // Read
);
   initial begin
      ptr_o = 8'h00;
      wr_o = 1'b0;
      wdata_o = 8'h00;
      rd_o = 1'b0;
   end
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic n);
      @(negedge clk_i);
      ptr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      // Stale data is inverted so a late sample cannot pass by luck
      wdata_o = ~d;
      n = nack_i;
   endtask : write_reg
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      ptr_o = a;
      rd_o = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      d = rdata_i;
   endtask : read_reg
endmodule : tsrm_host_model
`default_nettype wire

// ### tb/tsrm_reg_bank_asserts.sv
// Port checker for the temperature sensor register bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tsrm_reg_bank_chk (
   input wire logic CLOCK_I, // Clock
   input wire logic SRST_I, // Reset
   input wire logic [7:0] PTR_I, // Pointer
   input wire logic WR_I, // Write
   input wire logic [7:0] WDATA_I, // Data
   input wire logic RD_I, // Read
   input wire logic [7:0] RDATA_O, // Read data
   input wire logic WR_NACK_O, // Refusal
   input wire logic ONE_SHOT_O, // One-shot
   input wire logic [7:0] CONFIG_O, // Config
   input wire logic [7:0] CONV_INT_O, // Interval
   input wire logic [7:0] LOCAL_HIGH_O, // Limit
   input wire logic [7:0] REMOTE_CRIT_INIT_I, // Power-up
   input wire logic [7:0] REMOTE_CRIT_O, // Critical
   input wire logic CONV_DONE_I, // Done
   input wire logic ARA_HIT_I, // Alert response
   input wire logic [10:0] REMOTE_TEMP_O // Remote
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (SRST_I);
   logic ok_wr;
   assign ok_wr = WR_I && (PTR_I inside {8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0D,
      8'h0E, 8'h0F, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16, 8'h19, 8'h20, 8'h21, 8'h2D, 8'h2E, 8'h2F, 8'hBF});
   a_oneshot_pulse: assert property (WR_I && PTR_I == 8'h0F |-> ##1 ONE_SHOT_O)
      else $error("one-shot pulse missing");
   a_oneshot_cause: assert property (ONE_SHOT_O |-> $past(WR_I) && $past(PTR_I) == 8'h0F)
      else $error("one-shot without write");
   a_bad_wr_nack: assert property (WR_I && !ok_wr |=> WR_NACK_O)
      else $error("refused write not flagged");
   a_good_wr_ack: assert property (ok_wr |=> !WR_NACK_O)
      else $error("legal write flagged");
   a_bad_wr_keep: assert property (WR_I && !ok_wr |=> $stable(LOCAL_HIGH_O) && $stable(CONV_INT_O))
      else $error("refused write changed state");
   a_config_alias: assert property (WR_I && !ARA_HIT_I && PTR_I inside {8'h03, 8'h09}
      |=> CONFIG_O == $past(WDATA_I)) else $error("config write lost");
   a_interval_alias: assert property (WR_I && PTR_I inside {8'h04, 8'h0A}
      |=> CONV_INT_O == $past(WDATA_I)) else $error("interval write lost");
   a_remote_hi_rd: assert property (RD_I && !CONV_DONE_I && PTR_I == 8'h01
      |=> RDATA_O == REMOTE_TEMP_O[10:3]) else $error("remote high byte wrong");
   a_remote_lo_rd: assert property (RD_I && !CONV_DONE_I && PTR_I == 8'h10
      |=> RDATA_O == {REMOTE_TEMP_O[2:0], 5'h00}) else $error("remote low byte wrong");
   a_reserved_zero: assert property (RD_I && PTR_I inside {8'h06, 8'h0C, 8'h0F, 8'h15, 8'h55}
      |=> RDATA_O == 8'h00) else $error("reserved read not zero");
   a_crit_power_up: assert property ($fell(SRST_I) |=> REMOTE_CRIT_O == $past(REMOTE_CRIT_INIT_I))
      else $error("critical limit not loaded");
endmodule : tsrm_reg_bank_chk
bind tsrm_reg_bank tsrm_reg_bank_chk tsrm_reg_bank_chk_inst (.CLOCK_I(CLOCK_I), .SRST_I(SRST_I),
   .PTR_I(PTR_I), .WR_I(WR_I), .WDATA_I(WDATA_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .WR_NACK_O(WR_NACK_O),
   .ONE_SHOT_O(ONE_SHOT_O), .CONFIG_O(CONFIG_O), .CONV_INT_O(CONV_INT_O), .LOCAL_HIGH_O(LOCAL_HIGH_O),
   .REMOTE_CRIT_INIT_I(REMOTE_CRIT_INIT_I), .REMOTE_CRIT_O(REMOTE_CRIT_O), .CONV_DONE_I(CONV_DONE_I),
   .ARA_HIT_I(ARA_HIT_I), .REMOTE_TEMP_O(REMOTE_TEMP_O));
`default_nettype wire

// ### tb/tsrm_reg_bank_tb_top.sv
// Self-checking bench for the temperature sensor register bank.
// Assumes the host model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module tsrm_reg_bank_tb_top;
   logic clk, srst, done, busy, opn, ara, nack, one_shot;
   logic [7:0] ptr, wdata, rdata, lt, ev, cfg;
   logic wr, rd;
   logic [10:0] raw;
   logic [7:0] conv_int, lhigh, amsk, rcrit, lcrit, hyst, filt;
   logic [15:0] rhigh, rlow;
   logic [10:0] rtemp;
   int bad_count, cmp_count;
   // Entries are {pointer, expected}; identity values match the arbitrary defaults
   localparam logic [15:0] RST_TAB [33] = '{16'h0000, 16'h0100, 16'h0200, 16'h0305, 16'h0905, 16'h0408,
      16'h0A08, 16'h0546, 16'h0B46, 16'h0600, 16'h0746, 16'h0D46, 16'h08D8, 16'h0ED8, 16'h0C00, 16'h0F00,
      16'h1000, 16'h1100, 16'h1200, 16'h1300, 16'h1400, 16'h1607, 16'h196E, 16'h205F, 16'h210A, 16'h2D00,
      16'h2E00, 16'h2F00, 16'hBF00, 16'hFDA1, 16'hFEB2, 16'hFFC3, 16'h5500};
   localparam logic [15:0] RW_TAB [17] = '{16'h0309, 16'h040A, 16'h050B, 16'h070D, 16'h080E, 16'h1111,
      16'h1212, 16'h1313, 16'h1414, 16'h1616, 16'h1919, 16'h2020, 16'h2121, 16'h2D2D, 16'h2E2E, 16'h2F2F,
      16'hBFBF};
   localparam logic [15:0] RO_TAB [10] = '{16'h0000, 16'h0100, 16'h0200, 16'h0600, 16'h0C00, 16'h1000,
      16'hFDA1, 16'hFEB2, 16'hFFC3, 16'h5500};
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   tsrm_reg_bank tsrm_reg_bank_inst (.CLOCK_I(clk), .SRST_I(srst), .PTR_I(ptr), .WR_I(wr), .WDATA_I(wdata),
      .RD_I(rd), .RDATA_O(rdata), .WR_NACK_O(nack), .REMOTE_CRIT_INIT_I(8'h6E), .LOCAL_CRIT_INIT_I(8'h5F),
      .CONV_DONE_I(done), .CONV_BUSY_I(busy), .REMOTE_OPEN_I(opn), .LOCAL_TEMP_I(lt), .REMOTE_RAW_I(raw),
      .LIMIT_EVENTS_I(ev), .ARA_HIT_I(ara), .ONE_SHOT_O(one_shot), .CONFIG_O(cfg), .CONV_INT_O(conv_int),
      .LOCAL_HIGH_O(lhigh), .REMOTE_HIGH_O(rhigh), .REMOTE_LOW_O(rlow), .ALERT_SRC_MASK_O(amsk),
      .REMOTE_CRIT_O(rcrit), .LOCAL_CRIT_O(lcrit), .CRIT_HYST_O(hyst), .FILTER_ALERT_O(filt),
      .REMOTE_TEMP_O(rtemp));
   tsrm_host_model tsrm_host_model_inst (.clk_i(clk), .rdata_i(rdata), .nack_i(nack), .ptr_o(ptr),
      .wr_o(wr), .wdata_o(wdata), .rd_o(rd));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      tsrm_host_model_inst.read_reg(a, v);
      chk($sformatf("reg %h", a), e, v);
   endtask : rd_chk
   task automatic wr_chk(input logic [7:0] a, input logic [7:0] v, input logic e);
      logic n;
      tsrm_host_model_inst.write_reg(a, v, n);
      chk($sformatf("nack %h", a), {7'h00, e}, {7'h00, n});
   endtask : wr_chk
   task automatic conv(input logic [7:0] e);
      @(negedge clk);
      ev = e;
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
   endtask : conv
   task automatic t_reset_values;
      foreach (RST_TAB[i]) rd_chk(RST_TAB[i][15:8], RST_TAB[i][7:0]);
      $display("reset values done");
   endtask : t_reset_values
   task automatic t_refused;
      foreach (RO_TAB[i]) begin
         wr_chk(RO_TAB[i][15:8], 8'h7E, 1'b1);
         rd_chk(RO_TAB[i][15:8], RO_TAB[i][7:0]);
      end
      $display("refused writes done");
   endtask : t_refused
   task automatic t_rw_alias;
      // Each write lands at one pointer and is read back through its alias, or through the same pointer where there is none
      foreach (RW_TAB[i]) begin
         wr_chk(RW_TAB[i][15:8], RW_TAB[i][15:8] + 8'h01, 1'b0);
         rd_chk(RW_TAB[i][7:0], RW_TAB[i][15:8] + 8'h01);
         wr_chk(RW_TAB[i][7:0], RW_TAB[i][7:0] + 8'h01, 1'b0);
         rd_chk(RW_TAB[i][15:8], RW_TAB[i][7:0] + 8'h01);
      end
      // The register outputs must show the last value written through either pointer
      chk("interval out", 8'h0B, conv_int);
      chk("local high out", 8'h0C, lhigh);
      chk("remote high out hi", 8'h0E, rhigh[15:8]);
      chk("remote high out lo", 8'h14, rhigh[7:0]);
      chk("remote low out hi", 8'h0F, rlow[15:8]);
      chk("remote low out lo", 8'h15, rlow[7:0]);
      chk("mask out", 8'h17, amsk);
      chk("remote crit out", 8'h1A, rcrit);
      chk("local crit out", 8'h21, lcrit);
      chk("hysteresis out", 8'h22, hyst);
      chk("filter out", 8'hC0, filt);
      $display("read-write and aliases done");
   endtask : t_rw_alias
   task automatic t_one_shot;
      wr_chk(8'h0F, 8'h01, 1'b0);
      chk("one-shot", 8'h01, {7'h00, one_shot});
      @(negedge clk);
      chk("one-shot end", 8'h00, {7'h00, one_shot});
      rd_chk(8'h0F, 8'h00);
      $display("one-shot done");
   endtask : t_one_shot
   task automatic t_conversion;
      // Raw -25.750 plus an offset of 1.125 gives -24.625
      wr_chk(8'h11, 8'h01, 1'b0);
      wr_chk(8'h12, 8'h20, 1'b0);
      lt = 8'hE7;
      raw = 11'h732;
      conv(8'h00);
      rd_chk(8'h00, 8'hE7);
      rd_chk(8'h01, 8'hE7);
      rd_chk(8'h10, 8'h60);
      chk("remote out hi", 8'hE7, rtemp[10:3]);
      chk("remote out lo", 8'h03, {5'h00, rtemp[2:0]});
      $display("conversion done");
   endtask : t_conversion
   task automatic t_status;
      busy = 1'b1;
      opn = 1'b1;
      conv(8'hFF);
      rd_chk(8'h02, 8'hDF);
      chk("config", 8'h8A, cfg);
      busy = 1'b0;
      opn = 1'b0;
      rd_chk(8'h02, 8'h00);
      conv(8'h40);
      rd_chk(8'h02, 8'h40);
      // An alert response sets the mask bit on its own
      wr_chk(8'h03, 8'h05, 1'b0);
      @(negedge clk);
      ara = 1'b1;
      @(negedge clk);
      ara = 1'b0;
      chk("config after alert response", 8'h85, cfg);
      $display("status flags done");
   endtask : t_status
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      srst = 1'b1;
      done = 1'b0;
      busy = 1'b0;
      opn = 1'b0;
      ara = 1'b0;
      lt = 8'h00;
      raw = 11'h000;
      ev = 8'h00;
      bad_count = 0;
      cmp_count = 0;
      repeat (3) @(negedge clk);
      srst = 1'b0;
      repeat (2) @(negedge clk);
      t_reset_values();
      t_refused();
      t_rw_alias();
      t_one_shot();
      t_conversion();
      t_status();
      report_and_stop();
   end
   initial begin
      // About 300 cycles are needed; the margin covers a stalled strobe
      repeat (5000) @(posedge clk);
      bad_count++;
      $display("ERROR watchdog expected finish seen hang");
      report_and_stop();
   end
endmodule : tsrm_reg_bank_tb_top
`default_nettype wire
